// File: hw/hsts_sequencer.sv
// Purpose: Hot swap power-up sequencing, fault timer control and limit selection.
// Assumes: Comparator results arrive as asynchronous levels; reference codes
//          come from converters on clk. nrst is held until supply lockout clears.
// Notes:   Analog current-limit computation stays outside; only codes are chosen.
//
// Overview of operation
// - Start-up limit only while power good low
// - Lower of pin and register start-up limit
// - Start-up limit never below 100 mV floor
// - Start-up register resets to maximum code
// - Register limit is main times (N+1)/16
// - Active reference is lowest candidate
// - Foldback reference clamped at 100 mV minimum
// - Two thresholds, four timer current sources
// - Reset period holds gate and timer low
// - Initial cycle pulls timer up 3 uA
// - Initial pull-up lasts at least 27 ms
// - Then 100 uA down to low threshold
// - Ready only with supply inside window
// - Breaker trip: 60 uA up, regulate gate
// - Trip cleared early: switch to 2 uA down
// - Timer high: gate off, fault, power good low
// - Latch-off: 2 uA down, refuse turn-on
// - Below low: re-enable by UV or command toggle
// - Retry pin low: restart after 10 s
// - Fault latched until enable, on, power cycle or retry restart

`timescale 1ns/1ps

module hsts_sequencer #(
    parameter int INIT_CYC = hsts_pkg::INIT_MIN_CYC,
    parameter int RETRY_WAIT_CYC = hsts_pkg::RETRY_CYC
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic nrst,
    input wire logic clk_en,
    // Asynchronous comparator results and pins
    input wire logic breaker_trip,
    input wire logic timer_above_high,
    input wire logic timer_below_low,
    input wire logic undervoltage_input,
    input wire logic overvoltage_input,
    input wire logic pwgin_above,
    input wire logic enable_pin,
    input wire logic retry_n_pin,
    // Reference codes in mV, synchronous to clk
    input wire logic [11:0] main_limit_ref,
    input wire logic [11:0] power_limit_ref,
    input wire logic [11:0] startup_limit_pin,
    // Management command port
    input wire logic [7:0] cmd_addr,
    input wire logic [7:0] cmd_wdata,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    output logic [7:0] cmd_rdata,
    // Power stage controls
    output logic gate_on,
    output logic gate_regulate,
    output logic [2:0] timer_src,
    output logic [11:0] active_limit_ref,
    output logic startup_limit_active,
    // Status pins
    output logic fault_out,
    output logic power_good_out
);

    // ------------------------------------------------------------
    // State record
    // ------------------------------------------------------------
    typedef struct packed {
        hsts_pkg::hsts_state_t st;
        logic [31:0] cnt;
        logic fault;
        logic pg;
        logic gate;
        logic regul;
        hsts_pkg::hsts_tsrc_t tsrc;
        logic op_on;
        logic [3:0] frac;
        logic [7:0] rdata;
        logic en_prev;
        logic uv_dip;
        logic op_dip;
        logic [11:0] lim;
        logic su_act;
    } hsts_st_t;

    hsts_st_t st_reg;
    hsts_st_t st_next;

    logic [hsts_pkg::SYN_W-1:0] syn_in;
    logic [hsts_pkg::SYN_W-1:0] syn;
    logic s_cb;
    logic s_th;
    logic s_tl;
    logic s_uv;
    logic s_ov;
    logic s_pg;
    logic s_en;
    logic s_retry_n;

    // ------------------------------------------------------------
    // Synchronisers for every asynchronous level
    // ------------------------------------------------------------
    assign syn_in[hsts_pkg::SI_CB] = breaker_trip;
    assign syn_in[hsts_pkg::SI_TH] = timer_above_high;
    assign syn_in[hsts_pkg::SI_TL] = timer_below_low;
    assign syn_in[hsts_pkg::SI_UV] = undervoltage_input;
    assign syn_in[hsts_pkg::SI_OV] = overvoltage_input;
    assign syn_in[hsts_pkg::SI_PG] = pwgin_above;
    assign syn_in[hsts_pkg::SI_EN] = enable_pin;
    assign syn_in[hsts_pkg::SI_RETRY_N] = retry_n_pin;

    hsts_sync #(
        .W(hsts_pkg::SYN_W)
    ) u_sync (
        .clk(clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .d(syn_in),
        .q(syn)
    );

    assign s_cb = syn[hsts_pkg::SI_CB];
    assign s_th = syn[hsts_pkg::SI_TH];
    assign s_tl = syn[hsts_pkg::SI_TL];
    assign s_uv = syn[hsts_pkg::SI_UV];
    assign s_ov = syn[hsts_pkg::SI_OV];
    assign s_pg = syn[hsts_pkg::SI_PG];
    assign s_en = syn[hsts_pkg::SI_EN];
    assign s_retry_n = syn[hsts_pkg::SI_RETRY_N];

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic [16:0] prod;
        logic [11:0] su_reg;
        logic [11:0] su;
        logic [11:0] pl;
        logic [11:0] cand;
        logic op_wr;
        logic op_on_edge;
        logic pc;
        logic en_rise;
        logic supply_ok;
        logic run_ok;
        prod = '0;
        su_reg = '0;
        su = '0;
        pl = '0;
        cand = '0;
        op_wr = 1'b0;
        op_on_edge = 1'b0;
        pc = 1'b0;
        en_rise = 1'b0;
        supply_ok = 1'b0;
        run_ok = 1'b0;
        st_next = st_reg;

        // Command writes; power cycle is a write-only strobe
        if (cmd_wr) begin
            case (cmd_addr)
                hsts_pkg::ADDR_OPERATION: begin
                    op_wr = 1'b1;
                end
                hsts_pkg::ADDR_STARTUP_FRAC: begin
                    st_next.frac = cmd_wdata[3:0];
                end
                hsts_pkg::ADDR_POWER_CYCLE: begin
                    pc = 1'b1;
                end
                default: begin
                end
            endcase
        end
        op_on_edge = op_wr && cmd_wdata[hsts_pkg::OP_ON_BIT] && !st_reg.op_on;
        if (op_wr) begin
            st_next.op_on = cmd_wdata[hsts_pkg::OP_ON_BIT];
        end

        // Reads answer one cycle later; unknown codes read zero
        if (cmd_rd) begin
            case (cmd_addr)
                hsts_pkg::ADDR_OPERATION: begin
                    st_next.rdata = {st_reg.op_on, 7'h00};
                end
                hsts_pkg::ADDR_STARTUP_FRAC: begin
                    st_next.rdata = {4'h0, st_reg.frac};
                end
                hsts_pkg::ADDR_STATUS: begin
                    st_next.rdata = {st_reg.fault, st_reg.pg, st_reg.gate, st_reg.su_act,
                                     st_reg.st};
                end
                default: begin
                    st_next.rdata = hsts_pkg::RDATA_UNMAPPED;
                end
            endcase
        end

        // Fault clear events; a fault still active keeps it set
        en_rise = s_en && !st_reg.en_prev;
        st_next.en_prev = s_en;
        if ((en_rise || op_on_edge || pc) && !s_cb) begin
            st_next.fault = 1'b0;
        end

        supply_ok = s_uv && !s_ov;
        run_ok = supply_ok && s_en && st_reg.op_on;

        // Sequencer
        case (st_reg.st)
            hsts_pkg::ST_RESET: begin
                st_next.gate = 1'b0;
                st_next.regul = 1'b0;
                st_next.tsrc = hsts_pkg::TS_LOW;
                st_next.cnt = st_reg.cnt + 32'h1;
                if (st_reg.cnt >= 32'(hsts_pkg::RST_CYC - 1)) begin
                    st_next.cnt = '0;
                    st_next.st = hsts_pkg::ST_INIT_UP;
                end
            end
            hsts_pkg::ST_INIT_UP: begin
                // Reaching high early: hold at the rail so the 27 ms minimum stands
                st_next.tsrc = s_th ? hsts_pkg::TS_RAIL : hsts_pkg::TS_UP3;
                if (st_reg.cnt < 32'(INIT_CYC - 1)) begin
                    st_next.cnt = st_reg.cnt + 32'h1;
                end
                if (s_th && st_reg.cnt >= 32'(INIT_CYC - 1)) begin
                    st_next.st = hsts_pkg::ST_INIT_DN;
                    st_next.tsrc = hsts_pkg::TS_DN100;
                end
            end
            hsts_pkg::ST_INIT_DN: begin
                st_next.tsrc = hsts_pkg::TS_DN100;
                if (s_tl) begin
                    st_next.st = hsts_pkg::ST_WAIT_ON;
                    st_next.tsrc = hsts_pkg::TS_DN2;
                end
            end
            hsts_pkg::ST_WAIT_ON: begin
                st_next.gate = 1'b0;
                st_next.regul = 1'b0;
                st_next.tsrc = hsts_pkg::TS_DN2;
                if (run_ok) begin
                    st_next.st = hsts_pkg::ST_ON;
                    st_next.gate = 1'b1;
                end
            end
            hsts_pkg::ST_ON: begin
                if (!run_ok) begin
                    st_next.st = hsts_pkg::ST_WAIT_ON;
                    st_next.gate = 1'b0;
                    st_next.regul = 1'b0;
                    st_next.tsrc = hsts_pkg::TS_DN2;
                end else if (s_cb && s_th) begin
                    // Overcurrent lasted the full fault time
                    st_next.gate = 1'b0;
                    st_next.regul = 1'b0;
                    st_next.fault = 1'b1;
                    st_next.tsrc = hsts_pkg::TS_DN2;
                    st_next.cnt = '0;
                    st_next.uv_dip = 1'b0;
                    st_next.op_dip = 1'b0;
                    st_next.st = s_retry_n ? hsts_pkg::ST_LATCH_DN
                                           : hsts_pkg::ST_RETRY;
                end else if (s_cb) begin
                    st_next.tsrc = hsts_pkg::TS_UP60;
                    st_next.regul = 1'b1;
                end else begin
                    st_next.tsrc = hsts_pkg::TS_DN2;
                    st_next.regul = 1'b0;
                end
            end
            hsts_pkg::ST_LATCH_DN: begin
                // Turn-on requests are ignored until the timer has discharged
                st_next.gate = 1'b0;
                st_next.tsrc = hsts_pkg::TS_DN2;
                if (s_tl) begin
                    st_next.st = hsts_pkg::ST_LATCH_OFF;
                end
            end
            hsts_pkg::ST_LATCH_OFF: begin
                st_next.gate = 1'b0;
                st_next.tsrc = hsts_pkg::TS_DN2;
                if (!s_uv) begin
                    st_next.uv_dip = 1'b1;
                end
                if (!st_reg.op_on) begin
                    st_next.op_dip = 1'b1;
                end
                if ((st_reg.uv_dip && s_uv) || (st_reg.op_dip && st_reg.op_on) || pc) begin
                    st_next.st = hsts_pkg::ST_WAIT_ON;
                end
            end
            hsts_pkg::ST_RETRY: begin
                st_next.gate = 1'b0;
                st_next.tsrc = hsts_pkg::TS_DN2;
                st_next.cnt = st_reg.cnt + 32'h1;
                if (st_reg.cnt >= 32'(RETRY_WAIT_CYC - 1)) begin
                    st_next.cnt = '0;
                    st_next.st = hsts_pkg::ST_WAIT_ON;
                    if (!s_cb) begin
                        st_next.fault = 1'b0;
                    end
                end
            end
            default: begin
                st_next.st = hsts_pkg::ST_RESET;
                st_next.cnt = '0;
            end
        endcase

        // Power good needs a running, fault-free channel with output up
        st_next.pg = (st_next.st == hsts_pkg::ST_ON) && st_next.gate && s_pg
                     && run_ok && !st_next.fault;

        // Limit selection: register fraction of main limit, pin, foldback
        prod = 17'(main_limit_ref) * 17'({1'b0, st_reg.frac} + 5'h01);
        su_reg = 12'(prod >> hsts_pkg::FRAC_SHIFT);
        su = su_reg;
        if (startup_limit_pin < hsts_pkg::RAIL_MV && startup_limit_pin < su) begin
            su = startup_limit_pin;
        end
        if (su < hsts_pkg::REF_FLOOR_MV) begin
            su = hsts_pkg::REF_FLOOR_MV;
        end
        pl = power_limit_ref;
        if (pl < hsts_pkg::REF_FLOOR_MV) begin
            pl = hsts_pkg::REF_FLOOR_MV;
        end
        cand = (pl < main_limit_ref) ? pl : main_limit_ref;
        st_next.su_act = !st_reg.pg;
        if (!st_reg.pg && su < cand) begin
            cand = su;
        end
        st_next.lim = cand;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Reset values are constants only; the start-up fraction opens at full scale
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '{st: hsts_pkg::ST_RESET, cnt: 32'h0, fault: 1'b0, pg: 1'b0,
                        gate: 1'b0, regul: 1'b0, tsrc: hsts_pkg::TS_LOW,
                        op_on: hsts_pkg::OP_ON_RST, frac: hsts_pkg::FRAC_RST,
                        rdata: 8'h00, en_prev: 1'b0, uv_dip: 1'b0, op_dip: 1'b0,
                        lim: hsts_pkg::REF_FLOOR_MV, su_act: 1'b1};
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs straight from the state register
    // ------------------------------------------------------------
    assign cmd_rdata = st_reg.rdata;
    assign gate_on = st_reg.gate;
    assign gate_regulate = st_reg.regul;
    assign timer_src = st_reg.tsrc;
    assign active_limit_ref = st_reg.lim;
    assign startup_limit_active = st_reg.su_act;
    assign fault_out = st_reg.fault;
    assign power_good_out = st_reg.pg;

endmodule

// File: hw/hsts_pkg.sv
// Purpose: Shared constants and types for the hot swap timer sequencer.
// Assumes: 100 MHz clock; reference codes are millivolts at the limit comparator.
// Notes:   Offsets, reset values, timing figures and state codes.

package hsts_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int RST_PERIOD_NS = 100;
    localparam int RST_CYC = (RST_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_MIN_MS = 27;
    localparam int INIT_MIN_CYC = INIT_MIN_MS * (1000000 / CLK_PERIOD_NS);
    localparam int RETRY_S = 10;
    localparam int RETRY_CYC = RETRY_S * (1000000000 / CLK_PERIOD_NS);

    // ------------------------------------------------------------
    // Register map (command codes of the management bus)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_OPERATION = 8'h01;
    localparam logic [7:0] ADDR_POWER_CYCLE = 8'hD9;
    localparam logic [7:0] ADDR_STARTUP_FRAC = 8'hF6;
    localparam logic [7:0] ADDR_STATUS = 8'hF7;
    localparam int OP_ON_BIT = 7;
    localparam logic OP_ON_RST = 1'b1;
    localparam logic [3:0] FRAC_RST = 4'hF;
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

    // ------------------------------------------------------------
    // Reference codes in mV at the limit comparator (sense x 50)
    // ------------------------------------------------------------
    localparam int REF_W = 12;
    localparam logic [11:0] REF_FLOOR_MV = 12'h064;
    localparam logic [11:0] RAIL_MV = 12'hA8C;
    localparam int FRAC_SHIFT = 4;

    // ------------------------------------------------------------
    // Comparator and pin bit positions in the synchroniser vector
    // ------------------------------------------------------------
    localparam int SYN_W = 8;
    localparam int SI_CB = 0;
    localparam int SI_TH = 1;
    localparam int SI_TL = 2;
    localparam int SI_UV = 3;
    localparam int SI_OV = 4;
    localparam int SI_PG = 5;
    localparam int SI_EN = 6;
    localparam int SI_RETRY_N = 7;

    // Timer current source selection
    typedef enum logic [2:0] {
        TS_OFF = 3'h0,
        TS_UP3 = 3'h1,
        TS_UP60 = 3'h2,
        TS_DN2 = 3'h3,
        TS_DN100 = 3'h4,
        TS_RAIL = 3'h5,
        TS_LOW = 3'h6
    } hsts_tsrc_t;

    // Sequencer states
    typedef enum logic [3:0] {
        ST_RESET = 4'h0,
        ST_INIT_UP = 4'h1,
        ST_INIT_DN = 4'h2,
        ST_WAIT_ON = 4'h3,
        ST_ON = 4'h4,
        ST_LATCH_DN = 4'h5,
        ST_LATCH_OFF = 4'h6,
        ST_RETRY = 4'h7
    } hsts_state_t;

endpackage

// File: hw/hsts_sync.sv
// Purpose: Three-stage synchroniser for asynchronous levels.
// Assumes: Inputs are levels; short glitches may be dropped.
// Notes:   Output changes only once stages two and three agree.

`timescale 1ns/1ps

module hsts_sync #(
    parameter int W = 8
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic nrst,
    input wire logic clk_en,
    // Levels in and filtered levels out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] o;
    } hsts_sync_st_t;

    hsts_sync_st_t st_reg;
    hsts_sync_st_t st_next;

    // Per bit: take the new level only where stages two and three agree
    always_comb begin
        st_next = st_reg;
        st_next.s1 = d;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        st_next.o = (st_reg.s2 & st_reg.s3) | (st_reg.o & (st_reg.s2 ^ st_reg.s3));
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '0;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign q = st_reg.o;

endmodule

// File: dv/hsts_seq_checker.sv
// Purpose: Port-level assertions for the hot swap timer sequencer.
// Assumes: clk_en held high, main_limit_ref never below the 100 mV floor.
// Notes:   A saturating edge counter times the start-up window.
`timescale 1ns/1ps
module hsts_seq_checker #(
    parameter int INIT_CYC = 200
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    input wire logic clk_en,
    // Watched inputs
    input wire logic breaker_trip,
    input wire logic timer_below_low,
    input wire logic undervoltage_input,
    input wire logic overvoltage_input,
    input wire logic enable_pin,
    input wire logic [11:0] main_limit_ref,
    // Watched outputs
    input wire logic gate_on,
    input wire logic gate_regulate,
    input wire logic [2:0] timer_src,
    input wire logic [11:0] active_limit_ref,
    input wire logic startup_limit_active,
    input wire logic fault_out,
    input wire logic power_good_out
);
    // ------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic run_ok;
    assign run_ok = undervoltage_input && !overvoltage_input && enable_pin;
    // Saturates so a long run never wraps back into the start-up window
    always_comb begin
        cnt_next = cnt_reg;
        if (clk_en && cnt_reg < 32'hFFFF) cnt_next = cnt_reg + 32'h1;
    end
    // Counts enabled edges since reset release
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) cnt_reg <= 32'h0;
        else cnt_reg <= cnt_next;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    reset_hold_a: assert property (cnt_reg < 10 |-> timer_src == hsts_pkg::TS_LOW && !gate_on)
        else $error("reset hold lost");
    init_phase_a: assert property (cnt_reg < 10 + INIT_CYC |-> !gate_on &&
        timer_src inside {hsts_pkg::TS_LOW, hsts_pkg::TS_UP3, hsts_pkg::TS_RAIL})
        else $error("init cut short");
    init_dn_a: assert property (timer_src == hsts_pkg::TS_DN100 |-> !gate_on && !power_good_out)
        else $error("gate on in init");
    su_follow_a: assert property (startup_limit_active == !$past(power_good_out))
        else $error("start-up flag wrong");
    lowest_ref_a: assert property (active_limit_ref <= $past(main_limit_ref))
        else $error("reference above main");
    ref_floor_a: assert property ($past(main_limit_ref) >= 12'h064 |-> active_limit_ref >= 12'h064)
        else $error("reference below floor");
    trip_up_a: assert property ((breaker_trip && gate_on) [*8] |->
        timer_src == hsts_pkg::TS_UP60 && gate_regulate)
        else $error("no fast pull-up");
    trip_drop_a: assert property ((!breaker_trip && gate_on) [*8] |->
        timer_src == hsts_pkg::TS_DN2 && !gate_regulate)
        else $error("no slow pull-down");
    fault_cut_a: assert property ($rose(fault_out) |-> !gate_on && !power_good_out &&
        timer_src == hsts_pkg::TS_DN2)
        else $error("fault without shutdown");
    latch_off_a: assert property (fault_out && !timer_below_low |=> !gate_on)
        else $error("turn-on while discharging");
    pg_cond_a: assert property (power_good_out |-> gate_on && !fault_out)
        else $error("bad power good");
    turn_on_a: assert property ($rose(gate_on) |-> $past(run_ok, 2))
        else $error("turn-on outside window");
    cover property ($rose(power_good_out));
    cover property ($rose(fault_out));
    cover property (timer_src == hsts_pkg::TS_DN100);
    cover property ($fell(startup_limit_active));
endmodule
bind hsts_sequencer hsts_seq_checker #(.INIT_CYC(INIT_CYC)) chk_u (.*);

// File: dv/hsts_power_stage.sv
// Purpose: Behavioural pass device, sense resistor and timing capacitor.
// Assumes: One mV of timer swing per uA of source per cycle.
// Notes:   Sense trips only while the bench asks and the gate conducts.
`timescale 1ns/1ps
module hsts_power_stage (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Overload request from the bench
    input wire logic overload_req,
    // Controls from the sequencer
    input wire logic gate_on,
    input wire logic [2:0] timer_src,
    // Comparator results back to the sequencer
    output logic breaker_trip,
    output logic timer_above_high,
    output logic timer_below_low,
    output logic pwgin_above
);
    // ------------------------------------------------------------
    // Timer capacitor
    // ------------------------------------------------------------
    int tmv;
    // Integrates the selected source; pull-downs stop at ground
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tmv <= 0;
        end else begin
            case (timer_src)
                hsts_pkg::TS_UP3: tmv <= tmv + 3;
                hsts_pkg::TS_UP60: tmv <= tmv + 60;
                hsts_pkg::TS_DN2: tmv <= (tmv > 2) ? tmv - 2 : 0;
                hsts_pkg::TS_DN100: tmv <= (tmv > 100) ? tmv - 100 : 0;
                hsts_pkg::TS_RAIL: tmv <= 2700;
                hsts_pkg::TS_LOW: tmv <= 0;
                default: tmv <= tmv;
            endcase
        end
    end
    // Comparators at 1 V and 0.2 V; output good while the gate conducts
    assign timer_above_high = (tmv >= 1000);
    assign timer_below_low = (tmv < 200);
    assign breaker_trip = overload_req && gate_on;
    assign pwgin_above = gate_on;
endmodule

// File: dv/tb.sv
// Purpose: Self-checking bench for the hot swap timer sequencer.
// Assumes: Init and retry counts cut to 400 and 300 cycles.
// Notes:   Inputs change on the falling edge only.
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0, nrst = 1'b0, clk_en = 1'b1, overload_req = 1'b0;
    logic breaker_trip, timer_above_high, timer_below_low, pwgin_above;
    logic undervoltage_input = 1'b0, overvoltage_input = 1'b0;
    logic enable_pin = 1'b1, retry_n_pin = 1'b1;
    logic [11:0] main_limit_ref = 12'h3E8;
    logic [11:0] power_limit_ref = 12'h7D0;
    logic [11:0] startup_limit_pin = 12'hA8C;
    logic [7:0] cmd_addr = 8'h00, cmd_wdata = 8'h00;
    logic cmd_wr = 1'b0, cmd_rd = 1'b0;
    logic [7:0] cmd_rdata;
    logic gate_on, gate_regulate, startup_limit_active, fault_out, power_good_out;
    logic [2:0] timer_src;
    logic [11:0] active_limit_ref;
    int n_errors = 0, comparisons = 0;
    // Limit table: frac, pin, power, expected
    logic [7:0] t_frac [6] = '{8'h0F, 8'h03, 8'h03, 8'h0F, 8'h0F, 8'h0F};
    logic [11:0] t_pin [6] = '{12'hA8C, 12'hA8C, 12'h096, 12'h032, 12'hA8C, 12'hA8C};
    logic [11:0] t_pwr [6] = '{12'h7D0, 12'h7D0, 12'h7D0, 12'h7D0, 12'h050, 12'h1F4};
    logic [11:0] t_exp [6] = '{12'h3E8, 12'h0FA, 12'h096, 12'h064, 12'h064, 12'h1F4};

    // Init count above the timer's own rise time, so the rail hold is reached
    hsts_sequencer #(.INIT_CYC(400), .RETRY_WAIT_CYC(300)) dut_u (.*);
    hsts_power_stage pm_u (.*);

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One command; read data settled on return
    task automatic cmd(input logic [7:0] a, input logic [7:0] d, input logic rd);
        @(negedge clk);
        cmd_addr = a;
        cmd_wdata = d;
        cmd_wr = !rd;
        cmd_rd = rd;
        @(negedge clk);
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
    endtask
    // Bounded wait for a high level
    task automatic wait_hi(ref logic s, input int lim);
        for (int i = 0; i < lim && s !== 1'b1; i++) @(negedge clk);
        check(s, 1'b1);
    endtask
    task automatic final_report();
        if (n_errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // 100 MHz clock
    initial begin
        forever #5 clk = ~clk;
    end
    // Run is about 3000 cycles; a hang ends well past that
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        final_report();
    end
    // Main sequence
    initial begin
        repeat (10) @(negedge clk);
        check(gate_on, 1'b0);
        check(timer_src, 3'h6);
        nrst = 1'b1;
        cmd(8'hF6, 8'h00, 1'b1);
        check(cmd_rdata, 8'h0F);
        cmd(8'h55, 8'h00, 1'b1);
        check(cmd_rdata, 8'h00);
        for (int i = 0; i < 6; i++) begin
            startup_limit_pin = t_pin[i];
            power_limit_ref = t_pwr[i];
            cmd(8'hF6, t_frac[i], 1'b0);
            repeat (2) @(negedge clk);
            check(active_limit_ref, t_exp[i]);
        end
        power_limit_ref = 12'h7D0;
        // Supply held outside the window: init ends in the wait state
        repeat (360) @(negedge clk);
        check(timer_src, 3'h5);
        repeat (340) @(negedge clk);
        cmd(8'hF7, 8'h00, 1'b1);
        check(cmd_rdata, 8'h13);
        undervoltage_input = 1'b1;
        wait_hi(power_good_out, 100);
        repeat (2) @(negedge clk);
        check(startup_limit_active, 1'b0);
        cmd(8'hF6, 8'h03, 1'b0);
        repeat (2) @(negedge clk);
        check(active_limit_ref, 12'h3E8);
        // Short overload ends before the timer reaches high
        overload_req = 1'b1;
        repeat (8) @(negedge clk);
        check(gate_regulate, 1'b1);
        overload_req = 1'b0;
        repeat (12) @(negedge clk);
        check(timer_src, 3'h3);
        check(fault_out, 1'b0);
        // Lasting overload latches off; no turn-on while discharging
        overload_req = 1'b1;
        wait_hi(fault_out, 100);
        check(power_good_out, 1'b0);
        overload_req = 1'b0;
        undervoltage_input = 1'b0;
        repeat (8) @(negedge clk);
        undervoltage_input = 1'b1;
        cmd(8'h01, 8'h80, 1'b0);
        repeat (20) @(negedge clk);
        check(gate_on, 1'b0);
        repeat (800) @(negedge clk);
        cmd(8'hF7, 8'h00, 1'b1);
        check(cmd_rdata, 8'h96);
        cmd(8'h01, 8'h00, 1'b0);
        cmd(8'h01, 8'h80, 1'b0);
        wait_hi(power_good_out, 100);
        // Second latch-off, re-enabled by toggling the supply monitor
        overload_req = 1'b1;
        wait_hi(fault_out, 100);
        overload_req = 1'b0;
        repeat (800) @(negedge clk);
        undervoltage_input = 1'b0;
        repeat (8) @(negedge clk);
        undervoltage_input = 1'b1;
        wait_hi(gate_on, 100);
        check(fault_out, 1'b1);
        cmd(8'hD9, 8'h00, 1'b0);
        wait_hi(power_good_out, 100);
        // Auto-retry restarts after the retry wait
        retry_n_pin = 1'b0;
        repeat (8) @(negedge clk);
        overload_req = 1'b1;
        wait_hi(fault_out, 100);
        overload_req = 1'b0;
        repeat (100) @(negedge clk);
        check(gate_on, 1'b0);
        wait_hi(power_good_out, 600);
        final_report();
    end
endmodule
